/* rtl/mig_pkg.sv */
package mig_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] MIG_IDX_CFG1 = 6'h00;
  localparam logic [5:0] MIG_IDX_SEL = 6'h01;
  localparam logic [5:0] MIG_IDX_DIV_LO = 6'h02;
  localparam logic [5:0] MIG_IDX_DIV_HI = 6'h03;
  localparam logic [5:0] MIG_IDX_CFG3 = 6'h05;
  localparam logic [5:0] MIG_IDX_DIRPOL0 = 6'h08;
  localparam logic [5:0] MIG_IDX_DIRPOL3 = 6'h0b;
  localparam logic [5:0] MIG_IDX_MASK1 = 6'h18;
  localparam logic [5:0] MIG_IDX_MASK2 = 6'h19;
  localparam logic [5:0] MIG_IDX_MASK3 = 6'h1a;
  localparam logic [5:0] MIG_IDX_MASK4 = 6'h1b;
  localparam logic [5:0] MIG_IDX_PMASK_LO = 6'h1c;
  localparam logic [5:0] MIG_IDX_PMASK_HI = 6'h1d;
  localparam logic [5:0] MIG_IDX_STAT1 = 6'h20;
  localparam logic [5:0] MIG_IDX_STAT2 = 6'h21;
  localparam logic [5:0] MIG_IDX_STAT3 = 6'h22;
  localparam logic [5:0] MIG_IDX_STAT4 = 6'h23;
  localparam logic [5:0] MIG_IDX_PST_LO = 6'h24;
  localparam logic [5:0] MIG_IDX_PST_HI = 6'h25;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MIG_B_MON = 0;
  localparam int MIG_B_INTEN = 1;
  localparam int MIG_B_INTCLR = 2;
  localparam int MIG_B_PIN16 = 0;
  localparam int MIG_B_CICLR = 1;
  localparam int MIG_B_P16POL = 6;
  localparam int MIG_B_P16DIR = 7;
  localparam int MIG_B_S4_OVERTEMP_LINE = 3;
  localparam int MIG_B_S4_AFC = 4;
  localparam int MIG_B_S4_CI = 6;
  localparam int MIG_B_S4_P16 = 7;
  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] MIG_RST_DIV = 16'h5555;
  localparam logic [7:0] MIG_FAN_TOUT = 8'hff;
  localparam logic [2:0] MIG_FAN_LAST = 3'h7;
  localparam logic [9:0] MIG_FAN_WORST = 10'h1fd;
  localparam logic [4:0] MIG_ACH_LAST = 5'h10;
  localparam int MIG_CLK_HZ = 125000000;
  localparam int MIG_OSC_HZ = 22500;
  typedef enum logic {MIG_FAN_IDLE, MIG_FAN_RUN} mig_fan_t;
endpackage

/* rtl/mig_top.sv */
// Behaviour
// - Fan channels measured in order zero to seven, then restart.
// - A channel ends at count 255 before second or fourth tach edge.
// - Channel worst case is 509 oscillator pulses times its prescaler.
// - Fan and analog sequences start together, otherwise independent.
// - High intrusion input latches status four bit 6 and interrupts.
// - Intrusion flag holds until the clear bit is written one.
// - Intrusion on battery alone latches; interrupt waits for main power.
// - Select register bit set makes shared pin general purpose.
// - Config three bit 0 set makes the overtemp pin general purpose.
// - Each pin has direction, polarity, status and mask bits.
// - Direction one means output, zero means input.
// - Polarity one active high, zero active low, both directions.
// - Input pin status is read-only and shows the asserted level.
// - Output pin status is writable and drives the asserted level.
// - Mask keeps pin status out of the interrupt; outputs auto-masked except pin sixteen.
// - All sources merge into one active-low interrupt output.
// - Out of limit when above high limit or at or below low limit.
// - Analog status follows each result; interrupt clear leaves it.
// - Mask one blocks its status bit from the interrupt.
// - Unmasked analog bits set a latch ORed into the interrupt.
// - After clear, analog latch waits two local temperature results.
// - Fan start or stop sets status four bit 4 with one-off interrupt.
// - Overtemp change sets bit 3, one-off interrupt, and channel bit.
// - Interrupt enabled only with enable bit high and clear bit low.
// - Status one read, alert response or clear bit clears analog, fan and one-off latches.
// - Fan count above limit sets fan status into its own latch.
`timescale 1ns/1ps
module mig_top import mig_pkg::*; #(
  parameter int OSC_DIV = MIG_CLK_HZ / MIG_OSC_HZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog results and limits
  input wire logic meas_valid_i,
  input wire logic [4:0] meas_chan_i,
  input wire logic [7:0] meas_value_i,
  input wire logic [7:0] meas_high_i,
  input wire logic [7:0] meas_low_i,
  input wire logic meas_local_i,
  input wire logic [63:0] fan_limit_i,
  input wire logic [1:0] overtemp_line_chan_i,
  input wire logic auto_fan_control_i,
  input wire logic afc_event_i,
  input wire logic ara_i,
  output logic monitor_run_o,
  // Pins
  input wire logic [15:0] gpio_i,
  output logic [15:0] gpio_o,
  output logic [15:0] gpio_oe_n_o,
  input wire logic shared_pin_io_i,
  output logic shared_pin_io_o,
  output logic shared_pin_io_oe_n_o,
  input wire logic intrusion_input_i,
  input wire logic backup_battery_supply_i,
  input wire logic main_power_i,
  output logic int_o,
  output logic int_oe_n_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [12:0] OSC_LAST = 13'(OSC_DIV - 1);
  typedef struct packed {
    logic ack;
    logic [7:0] dat;
    logic [7:0] cfg1;
    logic [7:0] sel;
    logic [15:0] div;
    logic [7:0] cfg3;
    logic [31:0] dirpol;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] mask3;
    logic [7:0] mask4;
    logic [15:0] pmask;
    logic [16:0] ast;
    logic [7:0] fst;
    logic [16:0] pout;
    logic ev_overtemp_line;
    logic ev_afc;
    logic ci;
    logic alatch;
    logic ablock;
    logic lwait;
    logic flatch;
    logic fblock;
    logic oneoff;
    logic [16:0] pin_m;
    logic [16:0] pin_s;
    logic [16:0] pin_p;
    logic [2:0] misc_m;
    logic [2:0] misc_s;
    mig_fan_t fan;
    logic [2:0] ch;
    logic [2:0] edges;
    logic [7:0] cnt;
    logic [2:0] pre;
    logic [12:0] osc;
    logic [9:0] steps;
    logic [16:0] pin_oe_n;
    logic int_oe_n;
  } mig_st_t;
  mig_st_t s_q, s_d;

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  logic [16:0] gact, gdir, gpol, gst, pmask17;
  logic [5:0] idx;
  logic take, wr, rd1, clr, tick, step, rise, an, fi, gi, ci_int, int_on;
  logic overtemp_line_chg, afc_new;
  logic [2:0] pre_last;
  logic [7:0] rdata, wd, lim;

  // Fan-shared pins are general purpose only when selected
  genvar gi_v;
  for (gi_v = 0; gi_v < 16; gi_v++) begin : g_pin
    if (gi_v < 8) begin : g_ded
      assign gact[gi_v] = 1'b1;
    end else begin : g_shr
      assign gact[gi_v] = s_q.sel[gi_v-8];
    end
    assign gdir[gi_v] = s_q.dirpol[2*gi_v];
    assign gpol[gi_v] = s_q.dirpol[2*gi_v+1];
  end
  assign gact[16] = s_q.cfg3[MIG_B_PIN16];
  assign gdir[16] = s_q.cfg3[MIG_B_P16DIR];
  assign gpol[16] = s_q.cfg3[MIG_B_P16POL];

  // Input status compares against polarity, output status is stored
  assign gst = gact & ((gdir & s_q.pout) |
               (~gdir & ~(s_q.pin_s ^ gpol)));
  assign pmask17 = {s_q.mask4[MIG_B_S4_P16], s_q.pmask};
  // Outputs self-mask so written data never interrupts, pin 16 aside
  assign gi = |(gst & ~pmask17 & ~{1'b0, gdir[15:0]});

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign idx = wb_adr_i[7:2];
  assign take = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr = take & wb_we_i & wb_sel_i[0];
  assign wd = wb_dat_i[7:0];
  assign rd1 = take & ~wb_we_i & (idx == MIG_IDX_STAT1);
  assign clr = rd1 | ara_i | s_q.cfg1[MIG_B_INTCLR];

  // Read data, unmapped indices read as zero
  always_comb begin
    unique case (idx)
      MIG_IDX_CFG1: rdata = s_q.cfg1;
      MIG_IDX_SEL: rdata = s_q.sel;
      MIG_IDX_DIV_LO: rdata = s_q.div[7:0];
      MIG_IDX_DIV_HI: rdata = s_q.div[15:8];
      MIG_IDX_CFG3: rdata = s_q.cfg3;
      6'h08: rdata = s_q.dirpol[7:0];
      6'h09: rdata = s_q.dirpol[15:8];
      6'h0a: rdata = s_q.dirpol[23:16];
      MIG_IDX_DIRPOL3: rdata = s_q.dirpol[31:24];
      MIG_IDX_MASK1: rdata = s_q.mask1;
      MIG_IDX_MASK2: rdata = s_q.mask2;
      MIG_IDX_MASK3: rdata = s_q.mask3;
      MIG_IDX_MASK4: rdata = s_q.mask4;
      MIG_IDX_PMASK_LO: rdata = s_q.pmask[7:0];
      MIG_IDX_PMASK_HI: rdata = s_q.pmask[15:8];
      MIG_IDX_STAT1: rdata = s_q.ast[7:0];
      MIG_IDX_STAT2: rdata = s_q.ast[15:8];
      MIG_IDX_STAT3: rdata = s_q.fst;
      MIG_IDX_STAT4: rdata = {gst[16], s_q.ci, 1'b0, s_q.ev_afc,
                              s_q.ev_overtemp_line, 2'b00, s_q.ast[16]};
      MIG_IDX_PST_LO: rdata = gst[7:0];
      MIG_IDX_PST_HI: rdata = gst[15:8];
      default: rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  assign an = |(s_q.ast & ~{s_q.mask4[0], s_q.mask2, s_q.mask1});
  assign fi = |(s_q.fst & ~s_q.mask3);
  // Battery-only intrusions stay latched but quiet until power is back
  assign ci_int = s_q.ci & s_q.misc_s[1] & ~s_q.mask4[MIG_B_S4_CI];
  assign overtemp_line_chg = ~s_q.cfg3[MIG_B_PIN16] & (s_q.pin_s[16] ^ s_q.pin_p[16]);
  assign afc_new = auto_fan_control_i & afc_event_i;
  assign int_on = s_q.cfg1[MIG_B_INTEN] & ~s_q.cfg1[MIG_B_INTCLR] &
                  (s_q.alatch | s_q.flatch | s_q.oneoff | gi | ci_int);

  // ----------------------------------------------------------------
  // Fan timing
  // ----------------------------------------------------------------
  assign tick = (s_q.osc == OSC_LAST);
  assign pre_last = 3'((4'h1 << s_q.div[2*s_q.ch +: 2]) - 4'h1);
  assign step = tick & (s_q.pre == pre_last);
  assign rise = ~s_q.sel[s_q.ch] & s_q.pin_s[8+s_q.ch] & ~s_q.pin_p[8+s_q.ch];
  assign lim = fan_limit_i[8*s_q.ch +: 8];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic done;
    logic loc;
    done = 1'b0;
    loc = meas_valid_i & meas_local_i;
    s_d = s_q;
    // Synchronisers and edge history
    s_d.pin_m = {shared_pin_io_i, gpio_i};
    s_d.pin_s = s_q.pin_m;
    s_d.pin_p = s_q.pin_s;
    s_d.misc_m = {backup_battery_supply_i, main_power_i, intrusion_input_i};
    s_d.misc_s = s_q.misc_m;
    // Bus answer one cycle after the request, then dropped
    s_d.ack = take;
    if (take && !wb_we_i) begin
      s_d.dat = rdata;
    end
    if (wr) begin
      unique case (idx)
        MIG_IDX_CFG1: s_d.cfg1 = wd;
        MIG_IDX_SEL: s_d.sel = wd;
        MIG_IDX_DIV_LO: s_d.div[7:0] = wd;
        MIG_IDX_DIV_HI: s_d.div[15:8] = wd;
        MIG_IDX_CFG3: s_d.cfg3 = wd;
        6'h08: s_d.dirpol[7:0] = wd;
        6'h09: s_d.dirpol[15:8] = wd;
        6'h0a: s_d.dirpol[23:16] = wd;
        MIG_IDX_DIRPOL3: s_d.dirpol[31:24] = wd;
        MIG_IDX_MASK1: s_d.mask1 = wd;
        MIG_IDX_MASK2: s_d.mask2 = wd;
        MIG_IDX_MASK3: s_d.mask3 = wd;
        MIG_IDX_MASK4: s_d.mask4 = wd;
        MIG_IDX_PMASK_LO: s_d.pmask[7:0] = wd;
        MIG_IDX_PMASK_HI: s_d.pmask[15:8] = wd;
        MIG_IDX_PST_LO: s_d.pout[7:0] = (wd & gdir[7:0]) |
                                        (s_q.pout[7:0] & ~gdir[7:0]);
        MIG_IDX_PST_HI: s_d.pout[15:8] = (wd & gdir[15:8]) |
                                         (s_q.pout[15:8] & ~gdir[15:8]);
        MIG_IDX_STAT4: if (gdir[16]) begin
          s_d.pout[16] = wd[MIG_B_S4_P16];
        end
        default: ;
      endcase
    end
    // Analog compare; status follows each result
    if (meas_valid_i && meas_chan_i <= MIG_ACH_LAST) begin
      s_d.ast[meas_chan_i] = (meas_value_i > meas_high_i) |
                             (meas_value_i <= meas_low_i);
    end
    // Overtemp change also flags its channel
    if (overtemp_line_chg) begin
      unique case (overtemp_line_chan_i)
        2'h0: s_d.ast[0] = 1'b1;
        2'h1: s_d.ast[1] = 1'b1;
        default: s_d.ast[16] = 1'b1;
      endcase
    end
    // One-off event bits drop at the next local result, set wins
    if (loc) begin
      s_d.ev_overtemp_line = 1'b0;
      s_d.ev_afc = 1'b0;
    end
    if (overtemp_line_chg) begin
      s_d.ev_overtemp_line = 1'b1;
    end
    if (afc_new) begin
      s_d.ev_afc = 1'b1;
    end
    // Intrusion latch on main or battery power, set wins over clear
    if (s_q.cfg3[MIG_B_CICLR]) begin
      s_d.ci = 1'b0;
    end
    if (s_q.misc_s[0] && (s_q.misc_s[1] || s_q.misc_s[2])) begin
      s_d.ci = 1'b1;
    end
    // Analog latch with two-result hold-off after a clear
    if (an && !s_q.ablock) begin
      s_d.alatch = 1'b1;
    end
    if (loc && s_q.ablock) begin
      s_d.lwait = 1'b1;
      if (s_q.lwait) begin
        s_d.ablock = 1'b0;
        s_d.lwait = 1'b0;
      end
    end
    if (fi && !s_q.fblock) begin
      s_d.flatch = 1'b1;
    end
    if (clr) begin
      s_d.alatch = 1'b0;
      s_d.ablock = 1'b1;
      s_d.lwait = 1'b0;
      s_d.flatch = 1'b0;
      s_d.fblock = 1'b1;
      s_d.oneoff = 1'b0;
    end
    // Edge events interrupt once; a new edge beats a clear
    if ((overtemp_line_chg && !s_q.mask4[MIG_B_S4_OVERTEMP_LINE]) ||
        (afc_new && !s_q.mask4[MIG_B_S4_AFC])) begin
      s_d.oneoff = 1'b1;
    end
    // Oscillator divider runs freely
    s_d.osc = tick ? 13'h0000 : s_q.osc + 13'h0001;
    // Fan sequencer, started by the same bit that starts analog
    unique case (s_q.fan)
      MIG_FAN_IDLE: begin
        if (s_q.cfg1[MIG_B_MON]) begin
          s_d.fan = MIG_FAN_RUN;
          s_d.ch = 3'h0;
          s_d.edges = 3'h0;
          s_d.cnt = 8'h00;
          s_d.pre = 3'h0;
          s_d.steps = 10'h000;
        end
      end
      MIG_FAN_RUN: begin
        if (tick) begin
          s_d.pre = step ? 3'h0 : s_q.pre + 3'h1;
        end
        if (rise) begin
          s_d.edges = s_q.edges + 3'h1;
          if (s_q.edges == 3'h1) begin
            s_d.cnt = 8'h00;
            s_d.pre = 3'h0;
          end
          if (s_q.edges == 3'h3) begin
            done = 1'b1;
          end
        end else if (step) begin
          s_d.steps = s_q.steps + 10'h001;
          if (s_q.cnt == MIG_FAN_TOUT) begin
            done = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
        if (done) begin
          if (!s_q.sel[s_q.ch]) begin
            s_d.fst[s_q.ch] = s_q.cnt > lim;
          end
          s_d.ch = s_q.ch + 3'h1;
          s_d.edges = 3'h0;
          s_d.cnt = 8'h00;
          s_d.pre = 3'h0;
          s_d.steps = 10'h000;
          if (s_q.ch == MIG_FAN_LAST) begin
            s_d.fblock = 1'b0;
          end
        end
        if (!s_q.cfg1[MIG_B_MON]) begin
          s_d.fan = MIG_FAN_IDLE;
        end
      end
    endcase
    // Open drain: pull low when status and polarity differ, so the pin level is low
    s_d.pin_oe_n = ~(gact & gdir & (gpol ^ s_d.pout));
    s_d.int_oe_n = ~int_on;
    if (rst_i) begin
      s_d = '0;
      // Keep sampling pins so no false tach or overtemp edge after reset
      s_d.pin_m = {shared_pin_io_i, gpio_i};
      s_d.pin_s = s_q.pin_m;
      s_d.pin_p = s_q.pin_s;
      s_d.div = MIG_RST_DIV;
      s_d.pin_oe_n = '1;
      s_d.int_oe_n = 1'b1;
    end
  end

  // Single register stage for all state
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {24'h000000, s_q.dat};
  assign monitor_run_o = s_q.cfg1[MIG_B_MON];
  assign gpio_o = 16'h0000;
  assign gpio_oe_n_o = s_q.pin_oe_n[15:0];
  assign shared_pin_io_o = 1'b0;
  assign shared_pin_io_oe_n_o = s_q.pin_oe_n[16];
  assign int_o = 1'b0;
  assign int_oe_n_o = s_q.int_oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_fan_order;
    @(posedge clk_i) disable iff (rst_i)
    (s_q.fan == MIG_FAN_RUN && s_d.fan == MIG_FAN_RUN &&
     s_d.ch != s_q.ch) |=> (s_q.ch == 3'($past(s_q.ch) + 3'h1));
  endproperty
  a_fan_order: assert property (p_fan_order) else $error("bad order");
  property p_tout;
    @(posedge clk_i) disable iff (rst_i)
    (s_q.fan == MIG_FAN_RUN && s_q.cfg1[0] && step && !rise &&
     s_q.cnt == MIG_FAN_TOUT) |=> (s_q.cnt == 8'h00 && s_q.edges == 3'h0);
  endproperty
  a_tout: assert property (p_tout) else $error("no timeout");
  property p_worst;
    @(posedge clk_i) disable iff (rst_i)
    s_q.steps <= MIG_FAN_WORST + 10'h001;
  endproperty
  a_worst: assert property (p_worst) else $error("too long");
  property p_ci_hold;
    @(posedge clk_i) disable iff (rst_i)
    (s_q.ci && !s_q.cfg3[MIG_B_CICLR]) |=> s_q.ci;
  endproperty
  a_ci_hold: assert property (p_ci_hold) else $error("ci lost");
  property p_ci_pwr;
    @(posedge clk_i) disable iff (rst_i)
    (!s_q.misc_s[1] && !s_q.alatch && !s_q.flatch && !s_q.oneoff && !gi)
      |=> int_oe_n_o;
  endproperty
  a_ci_pwr: assert property (p_ci_pwr) else $error("ci no power");
  property p_cmp;
    @(posedge clk_i) disable iff (rst_i)
    (meas_valid_i && meas_chan_i <= MIG_ACH_LAST && !overtemp_line_chg &&
     meas_value_i > meas_high_i) |=> s_q.ast[$past(meas_chan_i)];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare");
  property p_block;
    @(posedge clk_i) disable iff (rst_i)
    s_q.ablock |-> !s_q.alatch;
  endproperty
  a_block: assert property (p_block) else $error("latch early");
  property p_en;
    @(posedge clk_i) disable iff (rst_i)
    !(s_q.cfg1[MIG_B_INTEN] && !s_q.cfg1[MIG_B_INTCLR]) |=> int_oe_n_o;
  endproperty
  a_en: assert property (p_en) else $error("int disabled");
  property p_clr;
    @(posedge clk_i) disable iff (rst_i)
    clr |=> (!s_q.alatch && !s_q.flatch) [*1] ##0 s_q.ablock;
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");
endmodule

/* verif/mig_board.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Board model: pull-ups and far-side pin drivers
// ----------------------------------------------------------------
module mig_board (
  // Design pin controls
  input wire logic [15:0] gpio_o,
  input wire logic [15:0] gpio_oe_n_o,
  input wire logic int_o,
  input wire logic int_oe_n_o,
  // Far-side drive, one means released to the pull-up
  input wire logic [15:0] ext_i,
  // Resolved wire levels
  output logic [15:0] pin_o,
  output logic int_line_o
);
  // Open drain: a low enable wins, else the far driver or pull-up
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      pin_o[k] = gpio_oe_n_o[k] ? ext_i[k] : gpio_o[k];
    end
    int_line_o = int_oe_n_o ? 1'b1 : int_o;
  end
endmodule

/* verif/mig_top_tb.sv */
`timescale 1ns/1ps
module mig_top_tb import mig_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, val = 8'h00, hi = 8'h00, lo = 8'h00, q, s1;
  logic [31:0] dat = 32'h0, rdat;
  logic [4:0] ch = 5'h00;
  logic mv = 1'b0, loc = 1'b0, afc = 1'b0, afe = 1'b0, ara = 1'b0;
  logic sh = 1'b1, ci = 1'b0, bat = 1'b1, pwr = 1'b1;
  logic [15:0] ext = 16'hffff, gpo, goe, pin;
  logic [63:0] flim = 64'hffffffffffffffff;
  logic ack, run, io_o, io_oe, ino, inoe, intl;
  int mismatches = 0, checked = 0;
  always #4 clk_i = ~clk_i;
  // Small divisor keeps the fan sequencer busy in a short run
  mig_top #(.OSC_DIV(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .meas_valid_i(mv), .meas_chan_i(ch), .meas_value_i(val),
    .meas_high_i(hi), .meas_low_i(lo), .meas_local_i(loc),
    .fan_limit_i(flim), .overtemp_line_chan_i(2'h0),
    .auto_fan_control_i(afc), .afc_event_i(afe), .ara_i(ara),
    .monitor_run_o(run), .gpio_i(pin), .gpio_o(gpo), .gpio_oe_n_o(goe),
    .shared_pin_io_i(sh), .shared_pin_io_o(io_o),
    .shared_pin_io_oe_n_o(io_oe), .intrusion_input_i(ci),
    .backup_battery_supply_i(bat), .main_power_i(pwr), .int_o(ino),
    .int_oe_n_o(inoe));
  mig_board board (.gpio_o(gpo), .gpio_oe_n_o(goe), .int_o(ino),
    .int_oe_n_o(inoe), .ext_i(ext), .pin_o(pin), .int_line_o(intl));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single cycle; read data taken at the ack edge
  task wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      mismatches++;
      test_done();
    end
  endtask
  task rd(input logic [5:0] idx, input logic [7:0] m, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk("register", q & m, e);
  endtask
  task meas(input logic [4:0] c, input logic [7:0] v, h, l, input logic lc);
    @(posedge clk_i);
    mv <= 1'b1;
    ch <= c;
    val <= v;
    hi <= h;
    lo <= l;
    loc <= lc;
    @(posedge clk_i);
    mv <= 1'b0;
    loc <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // Settled level of the pulled-up interrupt wire, low means asserted
  task irq(input logic e);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("int_line", {7'h0, intl}, {7'h0, e});
    @(posedge clk_i);
  endtask
  function automatic logic oob(logic [7:0] v, h, l);
    return (v > h) || (v <= l);
  endfunction
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha827f039));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(MIG_IDX_CFG1, 8'hff, 8'h00);
    rd(MIG_IDX_DIV_LO, 8'hff, MIG_RST_DIV[7:0]);
    rd(6'h3f, 8'hff, 8'h00);
    wb(1'b1, MIG_IDX_CFG1, 8'h03);
    @(negedge clk_i);
    chk("monitor_run", {7'h0, run}, 8'h01);
    meas(5'd0, 8'h20, 8'h20, 8'h10, 1'b0);
    rd(MIG_IDX_STAT1, 8'hff, 8'h00);
    // That read counts as a clear; two local results re-arm the latch
    meas(5'd16, 8'h20, 8'h30, 8'h10, 1'b1);
    meas(5'd16, 8'h20, 8'h30, 8'h10, 1'b1);
    irq(1'b1);
    meas(5'd0, 8'h21, 8'h20, 8'h10, 1'b0);
    irq(1'b0);
    rd(MIG_IDX_STAT1, 8'hff, 8'h01);
    irq(1'b1);
    meas(5'd0, 8'h21, 8'h20, 8'h10, 1'b0);
    irq(1'b1);
    meas(5'd16, 8'h20, 8'h30, 8'h10, 1'b1);
    irq(1'b1);
    wb(1'b1, MIG_IDX_MASK1, 8'h01);
    meas(5'd16, 8'h20, 8'h30, 8'h10, 1'b1);
    meas(5'd0, 8'h21, 8'h20, 8'h10, 1'b0);
    irq(1'b1);
    wb(1'b1, MIG_IDX_MASK1, 8'h00);
    irq(1'b0);
    // Random results, odd passes sit exactly on the low limit
    s1 = 8'h01;
    for (int i = 0; i < 8; i++) begin
      logic [4:0] rc;
      logic [7:0] rv, rh, rl;
      rc = 5'($urandom_range(7));
      rv = 8'($urandom);
      rh = 8'($urandom);
      rl = (i % 2) ? rv : 8'($urandom);
      s1[rc] = oob(rv, rh, rl);
      meas(rc, rv, rh, rl, 1'b0);
      rd(MIG_IDX_STAT1, 8'hff, s1);
    end
    for (int c = 0; c < 8; c++) begin
      meas(5'(c), 8'h20, 8'h30, 8'h10, 1'b0);
    end
    rd(MIG_IDX_STAT1, 8'hff, 8'h00);
    irq(1'b1);
    wb(1'b1, MIG_IDX_DIRPOL0, 8'h02);
    rd(MIG_IDX_PST_LO, 8'h01, 8'h01);
    irq(1'b0);
    wb(1'b1, MIG_IDX_PMASK_LO, 8'h01);
    irq(1'b1);
    ext[0] <= 1'b0;
    // Two synchroniser stages before the status can see the pin
    repeat (2) @(posedge clk_i);
    rd(MIG_IDX_PST_LO, 8'h01, 8'h00);
    wb(1'b1, MIG_IDX_PMASK_LO, 8'h00);
    wb(1'b1, MIG_IDX_DIRPOL0, 8'h01);
    ext[0] <= 1'b1;
    wb(1'b1, MIG_IDX_PST_LO, 8'h01);
    rd(MIG_IDX_PST_LO, 8'h01, 8'h01);
    irq(1'b1);
    chk("pin0", {7'h0, pin[0]}, 8'h00);
    wb(1'b1, MIG_IDX_DIRPOL0, 8'h03);
    irq(1'b1);
    chk("pin0", {7'h0, pin[0]}, 8'h01);
    wb(1'b1, MIG_IDX_DIRPOL0, 8'h00);
    // Intrusion while only the battery is up
    pwr <= 1'b0;
    ci <= 1'b1;
    repeat (6) @(posedge clk_i);
    ci <= 1'b0;
    irq(1'b1);
    pwr <= 1'b1;
    irq(1'b0);
    rd(MIG_IDX_STAT4, 8'h40, 8'h40);
    rd(MIG_IDX_STAT1, 8'hff, 8'h00);
    irq(1'b0);
    wb(1'b1, MIG_IDX_CFG3, 8'h02);
    wb(1'b1, MIG_IDX_CFG3, 8'h00);
    rd(MIG_IDX_STAT4, 8'h40, 8'h00);
    irq(1'b1);
    afc <= 1'b1;
    @(posedge clk_i);
    afe <= 1'b1;
    @(posedge clk_i);
    afe <= 1'b0;
    rd(MIG_IDX_STAT4, 8'h10, 8'h10);
    irq(1'b0);
    ara <= 1'b1;
    @(posedge clk_i);
    ara <= 1'b0;
    irq(1'b1);
    meas(5'd16, 8'h20, 8'h30, 8'h10, 1'b1);
    rd(MIG_IDX_STAT4, 8'h10, 8'h00);
    irq(1'b1);
    wb(1'b1, MIG_IDX_DIRPOL0, 8'h08);
    irq(1'b0);
    wb(1'b1, MIG_IDX_CFG1, 8'h01);
    irq(1'b1);
    // Zero limits: every timed-out fan channel reads as too slow
    wb(1'b1, MIG_IDX_DIRPOL0, 8'h00);
    flim <= 64'h0;
    repeat (18600) @(posedge clk_i);
    rd(MIG_IDX_STAT3, 8'hff, 8'hff);
    wb(1'b1, MIG_IDX_CFG1, 8'h03);
    irq(1'b0);
    wb(1'b1, MIG_IDX_MASK3, 8'hff);
    wb(1'b0, MIG_IDX_STAT1, 8'h00);
    irq(1'b1);
    // Overtemp edge interrupts once, not again while the line stays low
    sh <= 1'b0;
    repeat (2) @(posedge clk_i);
    irq(1'b0);
    rd(MIG_IDX_STAT4, 8'h08, 8'h08);
    rd(MIG_IDX_STAT1, 8'h01, 8'h01);
    irq(1'b1);
    // Shared pin as active-low output is not auto-masked
    wb(1'b1, MIG_IDX_CFG3, 8'h81);
    wb(1'b1, MIG_IDX_STAT4, 8'h80);
    @(negedge clk_i);
    chk("pin16_oe_n", {7'h0, io_oe}, 8'h00);
    irq(1'b0);
    test_done();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    test_done();
  end
endmodule
